//--- rsw_reset_unit.sv
// rsw_reset_unit: reset source selection, watchdog, soft resets and pin states in reset
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - select field 00 none, 01 strobe pin, 10 command/wake resets, 11 watchdog.
// - in strobe mode pin carries strobe and only hardware reset.
// - any internal reset event returns mode register to its reset value.
// - command code change gives reset pulse of 125 to 250 us.
// - long enough low wake pulse restarts oscillator and gives 125-250 us pulse.
// - selecting watchdog clears the watchdog timer and starts it.
// - missed service sets overflow flag and emits 125 us reset pulse.
// - with watchdog selected, software cannot change the select field.
// - hardware reset input resets everything and always reaches reset pin.
// - after hardware reset every register holds its reset value.
// - each soft reset bit holds its block in reset while set.
// - oscillator, data clock, host clock and reference stay on in reset.
// - bus handler reset drives frame sync high, strobe one low, floats bus pins.
// - codec reset floats speaker and handset outputs.
// - transceiver reset floats both line pins.
// - hardware reset floats serial data output and interrupt output.
// - hardware reset leaves reset pin at first falling bit clock edge after release.
// - generated pulse widths are counted in frame sync periods.
// - write-only soft reset register at top address with six block bits.
// - mode register trigger one bit 4, trigger two bit 3, select bits 1:0.
// - frame sync runs at 8 kHz from the line locked clock generator.
module rsw_reset_unit
	import rsw_pkg::*;
#(
	parameter int CMD_WIDTH = 4,
	parameter logic [5:0] DESIGN_ID = 6'h05 // arbitrary value
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic hwResetPinN,
	input wire logic wakeInputN,
	input wire logic [CMD_WIDTH-1:0] downstreamCommandCode,
	input wire logic frameSyncTick,
	input wire logic frameSyncIn,
	input wire logic bitClockFallTick,
	input wire logic dataClockIn,
	input wire logic serialStrobeTwo,
	input wire logic serialStrobeOne,
	input wire logic [rsw_pkg::PIN_COUNT-1:0] pinOeRequest,
	output logic resetOutOrStrobePin,
	output logic frameSyncOut,
	output logic serialStrobeOneOut,
	output logic [rsw_pkg::PIN_COUNT-1:0] pinOe,
	output logic [rsw_pkg::BLOCK_SOFT_RESET_REG_WIDTH-1:0] blockReset,
	output logic oscillatorStart,
	output logic oscillatorRun,
	output logic dataClockOut,
	output logic [1:0] mcuClockSelect,
	output logic referenceOn,
	output logic watchdogOverflowFlag
);
	logic hwPinSync1_q;
	logic hwPinSync2_q;
	logic wakeSync1_q;
	logic wakeSync2_q;
	logic hwActive;
	logic localClear;
	logic hwOut_q;
	logic [7:0] mode_q;
	logic [5:0] softReset_q;
	logic [CMD_WIDTH-1:0] cmdPrev_q;
	logic cmdLoaded_q;
	logic cmdChange;
	logic [3:0] wakeLowCnt_q;
	logic wakeEvent;
	logic wdgExpire;
	logic anyEvent;
	logic eventPulse;
	logic wdgPulse;
	logic modeWrite;
	logic wdgStart;
	logic busReset;
	logic codecReset;
	logic trxReset;
	logic [PIN_COUNT-1:0] pinReset;
	rsw_sel_t sel;

	rsw_frame_if frame ();

	// both external levels cross two flops before anything looks at them
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			hwPinSync1_q <= 1'b1;
			hwPinSync2_q <= 1'b1;
			wakeSync1_q <= 1'b1;
			wakeSync2_q <= 1'b1;
		end
		else
		begin
			hwPinSync1_q <= hwResetPinN;
			hwPinSync2_q <= hwPinSync1_q;
			wakeSync1_q <= wakeInputN;
			wakeSync2_q <= wakeSync1_q;
		end
	end

	// hardware reset clears the whole unit like the system reset
	assign hwActive = !hwPinSync2_q;
	assign localClear = sys_rst || hwActive;
	assign frame.frameTick = frameSyncTick;
	assign frame.clear = localClear;
	assign sel = rsw_sel_t'(mode_q[MODE_SEL_LSB +: 2]);

	// output side of hardware reset, released only on a falling bit clock
	always_ff @(posedge clk)
	begin
		if (sys_rst || hwActive)
			hwOut_q <= 1'b1;
		else if (bitClockFallTick)
			hwOut_q <= 1'b0;
	end

	// command channel change; the first code after reset is only a reference
	assign cmdChange = cmdLoaded_q && (downstreamCommandCode != cmdPrev_q);
	always_ff @(posedge clk)
	begin
		if (localClear)
		begin
			cmdPrev_q <= '0;
			cmdLoaded_q <= 1'b0;
		end
		else
		begin
			cmdPrev_q <= downstreamCommandCode;
			cmdLoaded_q <= 1'b1;
		end
	end

	// wake low filter: fires once per low pulse long enough to count
	assign wakeEvent = !wakeSync2_q && (wakeLowCnt_q == 4'(WAKE_MIN_CYC - 1));
	always_ff @(posedge clk)
	begin
		if (localClear || wakeSync2_q)
			wakeLowCnt_q <= 4'h0;
		else if (wakeLowCnt_q != 4'(WAKE_MIN_CYC))
			wakeLowCnt_q <= wakeLowCnt_q + 4'h1;
	end

	// oscillator restart request, also the reason wake works from power down
	always_ff @(posedge clk)
	begin
		if (localClear)
			oscillatorStart <= 1'b0;
		else
			oscillatorStart <= wakeEvent;
	end

	// every internal event resets the mode register, selected or not
	assign anyEvent = cmdChange || wakeEvent || wdgExpire;
	assign modeWrite = regWr && (regAddr == ADDR_MODE_ONE);
	assign wdgStart = modeWrite && (sel != RSW_SEL_WATCHDOG)
		&& (regWrData[MODE_SEL_LSB +: 2] == RSW_SEL_WATCHDOG);

	// mode register; event wins over a write in the same cycle
	always_ff @(posedge clk)
	begin
		if (localClear)
			mode_q <= MODE_RESET_VALUE;
		else if (anyEvent)
			mode_q <= MODE_RESET_VALUE;
		else if (modeWrite)
		begin
			mode_q[7:2] <= regWrData[7:2];
			if (sel != RSW_SEL_WATCHDOG)
				mode_q[MODE_SEL_LSB +: 2] <= regWrData[MODE_SEL_LSB +: 2];
		end
	end

	// soft reset bits stay set until software writes them low or a hardware reset clears them
	always_ff @(posedge clk)
	begin
		if (localClear)
			softReset_q <= BLOCK_SOFT_RESET_REG_RESET_VALUE;
		else if (regWr && (regAddr == ADDR_SOFT_RESET))
			softReset_q <= regWrData[BLOCK_SOFT_RESET_REG_WIDTH-1:0];
	end

	// overflow flag: set wins over the clearing read
	always_ff @(posedge clk)
	begin
		if (localClear)
			watchdogOverflowFlag <= 1'b0;
		else if (wdgExpire)
			watchdogOverflowFlag <= 1'b1;
		else if (regRd && (regAddr == ADDR_INT_STATUS))
			watchdogOverflowFlag <= 1'b0;
	end

	// read port; soft reset address is write-only and reads back the design code
	always_ff @(posedge clk)
	begin
		if (localClear)
			regRdData <= 8'h00;
		else if (regRd)
		begin
			case (regAddr)
				ADDR_INT_STATUS: regRdData <= 8'(watchdogOverflowFlag) << STATUS_WDG_OVF_BIT;
				ADDR_MODE_ONE: regRdData <= mode_q;
				ADDR_SOFT_RESET: regRdData <= {2'b00, DESIGN_ID};
				default: regRdData <= 8'h00;
			endcase
		end
	end

	rsw_watchdog #(.FRAMES(WDG_FRAMES)) u_watchdog
	(
		.clk(clk),
		.frame(frame),
		.enable(sel == RSW_SEL_WATCHDOG),
		.start(wdgStart),
		.serviceWrite(modeWrite),
		.trigOne(regWrData[MODE_TRIG_ONE_BIT]),
		.trigTwo(regWrData[MODE_TRIG_TWO_BIT]),
		.expire(wdgExpire)
	);

	// command and wake share one pulse; only a selected source starts it
	rsw_pulse_timer #(.EDGES(EVENT_PULSE_EDGES)) u_event_pulse
	(
		.clk(clk),
		.frame(frame),
		.trigger((cmdChange || wakeEvent) && (sel == RSW_SEL_WAKE_CMD)),
		.active(eventPulse)
	);

	// expiry comes one cycle after a frame tick, so one edge gives one frame less a clock
	rsw_pulse_timer #(.EDGES(WDG_PULSE_EDGES)) u_wdg_pulse
	(
		.clk(clk),
		.frame(frame),
		.trigger(wdgExpire),
		.active(wdgPulse)
	);

	// shared pin: hardware reset first, then strobe, then generated pulses
	always_ff @(posedge clk)
	begin
		if (sys_rst || hwOut_q)
			resetOutOrStrobePin <= 1'b0;
		else if (sel == RSW_SEL_STROBE)
			resetOutOrStrobePin <= serialStrobeTwo;
		else
			resetOutOrStrobePin <= !(eventPulse || wdgPulse);
	end

	// block resets follow the soft bits for as long as they are set
	assign busReset = hwOut_q || softReset_q[BLOCK_SOFT_RESET_REG_BUS_HANDLER];
	assign codecReset = hwOut_q || softReset_q[BLOCK_SOFT_RESET_REG_CODEC];
	assign trxReset = hwOut_q || softReset_q[BLOCK_SOFT_RESET_REG_TRANSCEIVER];
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			blockReset <= {BLOCK_SOFT_RESET_REG_WIDTH{1'b1}};
		else
			blockReset <= softReset_q | {BLOCK_SOFT_RESET_REG_WIDTH{hwOut_q}};
	end

	// frame sync forced high and strobe one low while the bus handler is reset
	always_ff @(posedge clk)
	begin
		if (sys_rst || busReset)
		begin
			frameSyncOut <= 1'b1;
			serialStrobeOneOut <= 1'b0;
		end
		else
		begin
			frameSyncOut <= frameSyncIn;
			serialStrobeOneOut <= serialStrobeOne;
		end
	end

	// which reset floats which pin
	always_comb
	begin
		pinReset = '0;
		pinReset[PIN_BIT_CLOCK] = busReset;
		pinReset[PIN_DATA_DOWN] = busReset;
		pinReset[PIN_DATA_UP] = busReset;
		pinReset[PIN_SPEAKER_POS] = codecReset;
		pinReset[PIN_SPEAKER_NEG] = codecReset;
		pinReset[PIN_HANDSET_POS] = codecReset;
		pinReset[PIN_HANDSET_NEG] = codecReset;
		pinReset[PIN_LINE_A] = trxReset;
		pinReset[PIN_LINE_B] = trxReset;
		pinReset[PIN_SERIAL_DATA] = hwOut_q;
		pinReset[PIN_INTERRUPT] = hwOut_q;
	end

	// per pin enable gate
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_pin
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					pinOe[gi] <= 1'b0;
				else
					pinOe[gi] <= pinOeRequest[gi] && !pinReset[gi];
			end
		end
	endgenerate

	// clocks and reference ignore every reset, so the host never loses its clock
	always_ff @(posedge clk)
	begin
		oscillatorRun <= 1'b1;
		referenceOn <= 1'b1;
		dataClockOut <= dataClockIn;
		mcuClockSelect <= mode_q[7:6];
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_strobe_mode;
		(sel == RSW_SEL_STROBE && !hwOut_q && !anyEvent) |=> resetOutOrStrobePin == $past(serialStrobeTwo);
	endproperty
	a_strobe_mode: assert property (p_strobe_mode) else $error("strobe not on shared pin");
	property p_hw_to_pin;
		hwActive |=> ##1 !resetOutOrStrobePin;
	endproperty
	a_hw_to_pin: assert property (p_hw_to_pin) else $error("hardware reset not forwarded");
	property p_hw_release_on_fall;
		$fell(hwOut_q) |-> $past(bitClockFallTick) && !$past(hwActive);
	endproperty
	a_hw_release_on_fall: assert property (p_hw_release_on_fall) else $error("release not on bit clock");
	property p_select_locked;
		(sel == RSW_SEL_WATCHDOG && !hwActive && !anyEvent) |=> sel == RSW_SEL_WATCHDOG;
	endproperty
	a_select_locked: assert property (p_select_locked) else $error("watchdog select changed");
	property p_event_defaults_mode;
		(anyEvent && !hwActive) |=> mode_q == MODE_RESET_VALUE;
	endproperty
	a_event_defaults_mode: assert property (p_event_defaults_mode) else $error("mode not defaulted");
	property p_soft_reset_holds;
		softReset_q[BLOCK_SOFT_RESET_REG_HDLC] |=> blockReset[BLOCK_SOFT_RESET_REG_HDLC];
	endproperty
	a_soft_reset_holds: assert property (p_soft_reset_holds) else $error("soft reset bit not applied");
	property p_bus_reset_pins;
		busReset |=> frameSyncOut && !serialStrobeOneOut && !pinOe[PIN_BIT_CLOCK];
	endproperty
	a_bus_reset_pins: assert property (p_bus_reset_pins) else $error("bus pins wrong in reset");
	property p_overflow_flag;
		(wdgExpire && !hwActive) |=> watchdogOverflowFlag ##1 !resetOutOrStrobePin || hwOut_q;
	endproperty
	a_overflow_flag: assert property (p_overflow_flag) else $error("watchdog expiry lost");
	c_cmd_pulse: cover property (cmdChange && sel == RSW_SEL_WAKE_CMD ##1 eventPulse);
	c_wake: cover property (wakeEvent);
	c_hw_release: cover property ($fell(hwOut_q));
endmodule // rsw_reset_unit
`default_nettype wire

//--- rsw_pkg.sv
// rsw_pkg: constants shared by the reset source and watchdog unit
`default_nettype none
package rsw_pkg;
	// register offsets
	localparam logic [7:0] ADDR_INT_STATUS = 8'h3c;
	localparam logic [7:0] ADDR_MODE_ONE = 8'h3d;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h3f;
	// mode_config_one field positions
	localparam int MODE_SEL_LSB = 0;
	localparam int MODE_TRIG_TWO_BIT = 3;
	localparam int MODE_TRIG_ONE_BIT = 4;
	localparam logic [7:0] MODE_RESET_VALUE = 8'h00;
	// interrupt_status_reg field position
	localparam int STATUS_WDG_OVF_BIT = 3;
	// block_soft_reset_reg field positions
	localparam int BLOCK_SOFT_RESET_REG_CODEC = 0;
	localparam int BLOCK_SOFT_RESET_REG_TRANSCEIVER = 1;
	localparam int BLOCK_SOFT_RESET_REG_BUS_HANDLER = 2;
	localparam int BLOCK_SOFT_RESET_REG_HDLC = 3;
	localparam int BLOCK_SOFT_RESET_REG_MONITOR = 4;
	localparam int BLOCK_SOFT_RESET_REG_CLOCK_PLL = 5;
	localparam int BLOCK_SOFT_RESET_REG_WIDTH = 6;
	localparam logic [5:0] BLOCK_SOFT_RESET_REG_RESET_VALUE = 6'h00;
	// reset source selection codes
	typedef enum logic [1:0]
	{
		RSW_SEL_NONE = 2'b00,
		RSW_SEL_STROBE = 2'b01,
		RSW_SEL_WAKE_CMD = 2'b10,
		RSW_SEL_WATCHDOG = 2'b11
	} rsw_sel_t;
	// timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int FRAME_PERIOD_US = 125;
	localparam int WDG_PERIOD_MS = 128;
	localparam int WDG_FRAMES = (WDG_PERIOD_MS * 1000) / FRAME_PERIOD_US;
	localparam int WAKE_MIN_NS = 65;
	localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int EVENT_PULSE_EDGES = 2;
	localparam int WDG_PULSE_EDGES = 1;
	// pin enable vector positions
	localparam int PIN_COUNT = 11;
	localparam int PIN_BIT_CLOCK = 0;
	localparam int PIN_DATA_DOWN = 1;
	localparam int PIN_DATA_UP = 2;
	localparam int PIN_SPEAKER_POS = 3;
	localparam int PIN_SPEAKER_NEG = 4;
	localparam int PIN_HANDSET_POS = 5;
	localparam int PIN_HANDSET_NEG = 6;
	localparam int PIN_LINE_A = 7;
	localparam int PIN_LINE_B = 8;
	localparam int PIN_SERIAL_DATA = 9;
	localparam int PIN_INTERRUPT = 10;
endpackage
`default_nettype wire

//--- rsw_frame_if.sv
// rsw_frame_if: frame sync tick and local clear shared with the timing submodules
`timescale 1ns/1ps
`default_nettype none
interface rsw_frame_if;
	logic frameTick;
	logic clear;
	modport source (output frameTick, output clear);
	modport user (input frameTick, input clear);
endinterface // rsw_frame_if
`default_nettype wire

//--- rsw_pulse_timer.sv
// rsw_pulse_timer: reset pulse whose end is counted in frame sync edges
`timescale 1ns/1ps
`default_nettype none
module rsw_pulse_timer
#(
	parameter int EDGES = 2
)
(
	input wire logic clk,
	rsw_frame_if.user frame,
	input wire logic trigger,
	output logic active
);
	logic [3:0] edgeCnt_q;

	// a retrigger restarts the count so the pulse never ends early
	always_ff @(posedge clk)
	begin
		if (frame.clear)
		begin
			active <= 1'b0;
			edgeCnt_q <= 4'h0;
		end
		else if (trigger)
		begin
			active <= 1'b1;
			edgeCnt_q <= 4'(EDGES);
		end
		else if (active && frame.frameTick)
		begin
			edgeCnt_q <= edgeCnt_q - 4'h1;
			if (edgeCnt_q == 4'h1)
				active <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (frame.clear);
	property p_pulse_start;
		trigger |=> active;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");
	property p_pulse_end_on_frame;
		$fell(active) |-> $past(frame.frameTick) && !$past(trigger);
	endproperty
	a_pulse_end_on_frame: assert property (p_pulse_end_on_frame) else $error("pulse ended off frame");
endmodule // rsw_pulse_timer
`default_nettype wire

//--- rsw_watchdog.sv
// rsw_watchdog: frame counted watchdog with two step service sequence
`timescale 1ns/1ps
`default_nettype none
module rsw_watchdog
	import rsw_pkg::*;
#(
	parameter int FRAMES = WDG_FRAMES
)
(
	input wire logic clk,
	rsw_frame_if.user frame,
	input wire logic enable,
	input wire logic start,
	input wire logic serviceWrite,
	input wire logic trigOne,
	input wire logic trigTwo,
	output logic expire
);
	logic [11:0] frameCnt_q;
	logic armed_q;
	logic serviced;

	// second step only counts after the first step was seen
	assign serviced = serviceWrite && armed_q && !trigOne && trigTwo;

	// service sequence tracker
	always_ff @(posedge clk)
	begin
		if (frame.clear || start || !enable)
			armed_q <= 1'b0;
		else if (serviceWrite)
			armed_q <= trigOne && !trigTwo;
	end

	// period counter; expiry restarts the period, but the mode reset it causes in the top unit deselects the watchdog, so one pulse
	always_ff @(posedge clk)
	begin
		expire <= 1'b0;
		if (frame.clear || start || !enable || serviced)
			frameCnt_q <= 12'h000;
		else if (frame.frameTick)
		begin
			if (frameCnt_q == 12'(FRAMES - 1))
			begin
				frameCnt_q <= 12'h000;
				expire <= 1'b1;
			end
			else
				frameCnt_q <= frameCnt_q + 12'h001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (frame.clear);
	property p_start_clears;
		start |=> frameCnt_q == 12'h000 && !expire;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start did not clear timer");
	property p_service_restarts;
		(enable && serviced) |=> frameCnt_q == 12'h000;
	endproperty
	a_service_restarts: assert property (p_service_restarts) else $error("service did not restart");
	property p_expire_at_period;
		expire |-> $past(frameCnt_q) == 12'(FRAMES - 1) && $past(frame.frameTick);
	endproperty
	a_expire_at_period: assert property (p_expire_at_period) else $error("early watchdog expiry");
	c_expire: cover property (expire);
endmodule // rsw_watchdog
`default_nettype wire

//--- rsw_far_model.sv
// rsw_far_model: line locked clock generator ticks seen by the reset unit
`timescale 1ns/1ps
`default_nettype none
module rsw_far_model
#(
	parameter int FRAME_CYC = 12,
	parameter int BIT_CYC = 4
)
(
	input wire logic clk,
	output logic frameSyncTick,
	output logic frameSyncIn,
	output logic bitClockFallTick,
	output logic dataClockIn
);
	int frameCnt = 0;
	int bitCnt = 0;
	// clocks run free, scaled down so that the watchdog count stays short in simulation
	always @(posedge clk)
	begin
		frameCnt <= (frameCnt + 1) % FRAME_CYC;
		bitCnt <= (bitCnt + 1) % BIT_CYC;
	end
	// outputs decoded from counters, so they only move just after a rising edge
	assign frameSyncTick = (frameCnt == FRAME_CYC - 1); // one tick per frame
	assign frameSyncIn = (frameCnt < FRAME_CYC / 2);
	assign bitClockFallTick = (bitCnt == BIT_CYC - 1);
	assign dataClockIn = bitCnt[0];
endmodule // rsw_far_model
`default_nettype wire

//--- tb.sv
// tb: self checking bench for the reset source and watchdog unit
`timescale 1ns/1ps
`default_nettype none
`define RSW_CHECK(name, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("[FAIL] %s expected %h seen %h", name, exp, got); \
		end \
	end
module tb;
	import rsw_pkg::*;
	localparam int FRAME_CYC = 12;
	localparam logic [5:0] DUT_ID = 6'h05; // arbitrary value
	logic clk;
	logic sys_rst;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWr;
	logic regRd;
	logic [7:0] regRdData;
	logic hwResetPinN;
	logic wakeInputN;
	logic [3:0] downstreamCommandCode;
	logic frameSyncTick;
	logic frameSyncIn;
	logic bitClockFallTick;
	logic dataClockIn;
	logic serialStrobeTwo;
	logic serialStrobeOne;
	logic [PIN_COUNT-1:0] pinOeRequest;
	logic resetOutOrStrobePin;
	logic frameSyncOut;
	logic serialStrobeOneOut;
	logic [PIN_COUNT-1:0] pinOe;
	logic [BLOCK_SOFT_RESET_REG_WIDTH-1:0] blockReset;
	logic oscillatorStart;
	logic oscillatorRun;
	logic dataClockOut;
	logic [1:0] mcuClockSelect;
	logic referenceOn;
	logic watchdogOverflowFlag;
	logic oscSeen;
	logic dclPrev;
	int bad_count;
	int samples_checked;
	int lowLen;
	int tickAge;

	rsw_reset_unit #(.CMD_WIDTH(4), .DESIGN_ID(DUT_ID)) i_dut
	(
		.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.hwResetPinN, .wakeInputN, .downstreamCommandCode, .frameSyncTick,
		.frameSyncIn, .bitClockFallTick, .dataClockIn, .serialStrobeTwo,
		.serialStrobeOne, .pinOeRequest, .resetOutOrStrobePin, .frameSyncOut,
		.serialStrobeOneOut, .pinOe, .blockReset, .oscillatorStart, .oscillatorRun,
		.dataClockOut, .mcuClockSelect, .referenceOn, .watchdogOverflowFlag
	);
	rsw_far_model #(.FRAME_CYC(FRAME_CYC), .BIT_CYC(4)) i_far
	(
		.clk, .frameSyncTick, .frameSyncIn, .bitClockFallTick, .dataClockIn
	);

	// free running clock, 8 ns period
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// remember oscillator starts and how long ago the bit clock last fell
	always @(posedge clk)
	begin
		if (oscillatorStart === 1'b1)
			oscSeen <= 1'b1;
		tickAge <= (bitClockFallTick === 1'b1) ? 0 : tickAge + 1;
		dclPrev <= dataClockIn;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// read data is registered, valid from the cycle after the strobe until the next read
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`RSW_CHECK(name, exp, regRdData)
	endtask

	task automatic wake(input int n);
		@(posedge clk);
		wakeInputN <= 1'b0;
		repeat (n) @(posedge clk);
		wakeInputN <= 1'b1;
	endtask

	// length of the next low pulse on the shared pin, 0 if none within the wait
	task automatic measure(input int waitCyc, output int len);
		int n;
		len = 0;
		n = 0;
		#1;
		while (resetOutOrStrobePin !== 1'b0 && n < waitCyc)
		begin
			cyc(1);
			n++;
		end
		while (resetOutOrStrobePin === 1'b0 && len < 4 * FRAME_CYC)
		begin
			cyc(1);
			len++;
		end
	endtask

	function automatic logic [PIN_COUNT-1:0] oeExp(input int i);
		oeExp = '1;
		case (i)
			BLOCK_SOFT_RESET_REG_BUS_HANDLER: oeExp[PIN_DATA_UP:PIN_BIT_CLOCK] = 3'b000;
			BLOCK_SOFT_RESET_REG_CODEC: oeExp[PIN_HANDSET_NEG:PIN_SPEAKER_POS] = 4'h0;
			BLOCK_SOFT_RESET_REG_TRANSCEIVER: oeExp[PIN_LINE_B:PIN_LINE_A] = 2'b00;
			default: oeExp = '1;
		endcase
	endfunction

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard: the whole run fits well inside this bound
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		$display("[FAIL] run limit reached");
		finish_test;
	end

	initial
	begin
		bad_count = 0;
		samples_checked = 0;
		oscSeen = 1'b0;
		tickAge = 0;
		sys_rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		hwResetPinN = 1'b1;
		wakeInputN = 1'b1;
		downstreamCommandCode = 4'h0;
		serialStrobeTwo = 1'b1;
		serialStrobeOne = 1'b1;
		pinOeRequest = '1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(2);
		rdchk(ADDR_MODE_ONE, MODE_RESET_VALUE, "mode reset");
		rdchk(ADDR_INT_STATUS, 8'h00, "status reset");
		rdchk(ADDR_SOFT_RESET, {2'b00, DUT_ID}, "id read");
		rdchk(8'h50, 8'h00, "unmapped read");
		`RSW_CHECK("soft idle", BLOCK_SOFT_RESET_REG_RESET_VALUE, blockReset)
		$display("test reset values done");
		// each soft bit alone, with the pin states it forces
		for (int i = 0; i < BLOCK_SOFT_RESET_REG_WIDTH; i++)
		begin
			wr(ADDR_SOFT_RESET, 8'h01 << i);
			cyc(3);
			`RSW_CHECK("soft bit", 6'h01 << i, blockReset)
			`RSW_CHECK("pin enables", oeExp(i), pinOe)
			`RSW_CHECK("bus pins", 1'b1, i != 2 || (frameSyncOut === 1'b1 && serialStrobeOneOut === 1'b0))
		end
		wr(ADDR_SOFT_RESET, 8'h00);
		cyc(3);
		`RSW_CHECK("soft clear", 6'h00, blockReset)
		$display("test soft reset done");
		// strobe mode: pin carries the strobe, events only clear the mode
		wr(ADDR_MODE_ONE, 8'h01);
		@(posedge clk);
		serialStrobeTwo <= 1'b0;
		cyc(3);
		`RSW_CHECK("strobe low", 1'b0, resetOutOrStrobePin)
		@(posedge clk);
		serialStrobeTwo <= 1'b1;
		@(posedge clk);
		downstreamCommandCode <= downstreamCommandCode + 4'h1;
		measure(4 * FRAME_CYC, lowLen);
		`RSW_CHECK("strobe no reset", 0, lowLen)
		rdchk(ADDR_MODE_ONE, 8'h00, "mode after strobe event");
		// command change with no source and with command/wake source
		for (int s = 0; s < 3; s += 2)
		begin
			wr(ADDR_MODE_ONE, 8'(s));
			@(posedge clk);
			downstreamCommandCode <= downstreamCommandCode + 4'h1;
			measure(4 * FRAME_CYC, lowLen);
			`RSW_CHECK("cmd pulse", s == 2, lowLen >= FRAME_CYC - 1 && lowLen <= 2 * FRAME_CYC + 1)
			rdchk(ADDR_MODE_ONE, 8'h00, "mode after cmd");
		end
		// a wake pulse below the minimum width is ignored, a long one resets
		wr(ADDR_MODE_ONE, 8'hc2);
		wake(5);
		measure(4 * FRAME_CYC, lowLen);
		`RSW_CHECK("short wake", 0, lowLen)
		rdchk(ADDR_MODE_ONE, 8'hc2, "mode after short wake");
		`RSW_CHECK("host clock select", 2'b11, mcuClockSelect)
		wake(12);
		measure(4 * FRAME_CYC, lowLen);
		`RSW_CHECK("wake pulse", 1'b1, lowLen >= FRAME_CYC - 1 && lowLen <= 2 * FRAME_CYC + 1)
		`RSW_CHECK("osc start", 1'b1, oscSeen)
		rdchk(ADDR_MODE_ONE, 8'h00, "mode after wake");
		`RSW_CHECK("host clock after wake", 2'b00, mcuClockSelect)
		$display("test source select done");
		// watchdog: locked select, two services, then let it expire
		wr(ADDR_MODE_ONE, 8'h03);
		wr(ADDR_MODE_ONE, 8'h01);
		rdchk(ADDR_MODE_ONE, 8'h03, "select locked");
		for (int k = 0; k < 2; k++)
		begin
			measure(700 * FRAME_CYC, lowLen);
			`RSW_CHECK("serviced", 0, lowLen)
			wr(ADDR_MODE_ONE, 8'h13);
			wr(ADDR_MODE_ONE, 8'h0b);
		end
		measure(1000 * FRAME_CYC, lowLen);
		`RSW_CHECK("no early expiry", 0, lowLen)
		measure(100 * FRAME_CYC, lowLen);
		`RSW_CHECK("expiry pulse", 1'b1, lowLen >= FRAME_CYC - 3 && lowLen <= FRAME_CYC + 1)
		`RSW_CHECK("overflow flag", 1'b1, watchdogOverflowFlag)
		rdchk(ADDR_INT_STATUS, 8'h01 << STATUS_WDG_OVF_BIT, "status overflow");
		rdchk(ADDR_INT_STATUS, 8'h00, "status cleared");
		rdchk(ADDR_MODE_ONE, 8'h00, "mode after expiry");
		$display("test watchdog done");
		// hardware reset overrides the lock and releases on a bit clock edge
		wr(ADDR_MODE_ONE, 8'h03);
		wr(ADDR_SOFT_RESET, 8'h3f);
		@(posedge clk);
		hwResetPinN <= 1'b0;
		cyc(6);
		`RSW_CHECK("hw pin", 1'b0, resetOutOrStrobePin)
		`RSW_CHECK("hw float", 2'b00, pinOe[PIN_INTERRUPT:PIN_SERIAL_DATA])
		`RSW_CHECK("kept running", 2'b11, {oscillatorRun, referenceOn})
		`RSW_CHECK("data clock in reset", dclPrev, dataClockOut)
		@(posedge clk);
		hwResetPinN <= 1'b1;
		for (int n = 0; n < 40 && resetOutOrStrobePin !== 1'b1; n++)
			cyc(1);
		`RSW_CHECK("hw released", 1'b1, resetOutOrStrobePin)
		`RSW_CHECK("release edge", 1, tickAge)
		rdchk(ADDR_MODE_ONE, 8'h00, "mode after hw");
		`RSW_CHECK("soft after hw", 6'h00, blockReset)
		$display("test hardware reset done");
		finish_test;
	end
endmodule // tb
`default_nettype wire
